// ### bench/ccmode_regs_monitor.sv
// Bus and field-mapping assertions for the channel mode/enable block
`timescale 1ns/1ps
`default_nettype none
module ccmode_regs_monitor (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Register bus
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Channel results
	input wire logic [1:0] capture_pulse,
	input wire logic [4:0] preload_en,
	input wire logic [1:0] fast_en,
	input wire logic [3:0] ch3_input_filter,
	input wire logic [3:0] ch4_input_filter
);
	logic [31:0] wd_q;
	// Last write word; it stays put until the response because the readies are low
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wd_q <= 32'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wd_q <= s_axi_wdata;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// Address and data taken at one edge; the full-word mode register case
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence mode_wr;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			&& s_axi_awaddr == 8'h1C && s_axi_wstrb == 4'hF;
	endsequence
	a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write response changed before taken");
	a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("read data changed before taken");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
		&& !s_axi_arready) else $error("read answer late");
	a_write_answer: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response not two edges after");
	a_busy_readies: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write readies up while response pending");
	a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready
		&& !(s_axi_araddr inside {8'h1C, 8'h20, 8'h40, 8'h44})
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read answer");
	a_preload_map: assert property (mode_wr |-> ##2 preload_en == {wd_q[26], wd_q[21],
		wd_q[16], wd_q[11], wd_q[3]}) else $error("preload bits misplaced");
	a_field_map: assert property (mode_wr |-> ##2 fast_en == {wd_q[10], wd_q[2]}
		&& ch3_input_filter == wd_q[7:4] && ch4_input_filter == wd_q[15:12])
		else $error("mode fields misplaced");
	a_capture_single: assert property (capture_pulse != 2'h0
		|=> (capture_pulse & $past(capture_pulse)) == 2'h0) else $error("capture pulse too long");
endmodule
bind ccmode_regs ccmode_regs_monitor ccmode_regs_monitor_inst (.*);
`default_nettype wire

// ### bench/ccmode_regs_tb.sv
// Self-checking bench: register model, output levels and capture counts
`timescale 1ns/1ps
`default_nettype none
`include "ccmode_consts.vh"
module ccmode_regs_tb;
	// Clock, reset, fixed enable and strobes, and the compare and clear inputs
	logic sys_clk = 0;
	logic rst_b = 0;
	logic clk_en = 1;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] cmp_match = 2'h0;
	logic [1:0] cmp_below = 2'h0;
	logic ref_clear_in = 0;
	// Bus master and pins
	logic [7:0] s_axi_awaddr = 8'h0;
	logic [7:0] s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic [2:0] pins = 3'h0;
	logic [3:0] oc_ref_in = 4'h0;
	wire timer_input_3 = pins[0];
	wire timer_input_4 = pins[1];
	wire internal_trigger_source = pins[2];
	// Design outputs
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp, capture_pulse, fast_en;
	wire [31:0] s_axi_rdata;
	wire [5:0] ch_output, ch_output_oe;
	wire [3:0] ch_comp_output, ch_comp_output_oe, ch3_input_filter, ch4_input_filter;
	wire [4:0] preload_en;
	// Model state and bookkeeping
	logic [31:0] mode_m = 32'h0, ccen_m = 32'h0, cfg_m = 32'h0, seed = 32'h78453E9B;
	int bad_count = 0, compares = 0, n3 = 0, n4 = 0;
	ccmode_regs #(.ADVANCED(1)) ccmode_regs_inst (.*);
	always #50 sys_clk = ~sys_clk;
	// Capture pulses counted away from the edge that launches them
	always @(negedge sys_clk) begin
		n3 += (capture_pulse[0] === 1'b1);
		n4 += (capture_pulse[1] === 1'b1);
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Pin that feeds a channel: 0 input 3, 1 input 4, 2 trigger, -1 none
	function automatic int src(input int dir, input int own, input int cfg);
		return dir == 1 ? own : dir == 2 ? 1 - own : (dir == 3 && cfg) ? 2 : -1;
	endfunction
	function automatic logic [1:0] exp_resp(input logic [7:0] a);
		return (a inside {8'h1C, 8'h20, 8'h40, 8'h44}) ? 2'h0 : 2'h2;
	endfunction
	task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_pin(input string nm, input logic e, input logic g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %b seen %b", nm, e, g);
		end
	endtask
	// Write: address and data offered together, each released at its own acceptance
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w, ta, tw;
		aw = 1;
		w = 1;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (aw || w) begin
			@(negedge sys_clk);
			ta = aw && s_axi_awready;
			tw = w && s_axi_wready;
			@(posedge sys_clk);
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
			aw = aw && !ta;
			w = w && !tw;
		end
		do @(negedge sys_clk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		@(posedge sys_clk);
		s_axi_bready <= 0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(negedge sys_clk); while (s_axi_arready !== 1'b1);
		@(posedge sys_clk);
		s_axi_arvalid <= 0;
		do @(negedge sys_clk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		@(posedge sys_clk);
		s_axi_rready <= 0;
	endtask
	// Write through the bus and into the model
	task automatic mwr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk_reg("bresp", exp_resp(a), r);
		if (a == `REG_MODE34_OFS) begin
			d = d & `MODE34_MASK_ADV;
			if (ccen_m[8]) d[1:0] = mode_m[1:0];
			if (ccen_m[12]) d[9:8] = mode_m[9:8];
			mode_m = d;
		end
		if (a == `REG_CCEN_OFS) ccen_m = d & `CCEN_MASK_ADV;
		if (a == `REG_CFG_OFS) cfg_m = d & `CFG_MASK;
	endtask
	task automatic mrd(input logic [7:0] a);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk_reg("rdata", a == 8'h1C ? mode_m : a == 8'h20 ? ccen_m : a == 8'h40 ? cfg_m : 0, d);
		chk_reg("rresp", exp_resp(a), r);
	endtask
	task automatic pulse(input int p);
		repeat (8) begin
			@(posedge sys_clk);
			pins[p] <= 1'b1;
			repeat (3) @(posedge sys_clk);
			pins[p] <= 1'b0;
			repeat (2) @(posedge sys_clk);
		end
		repeat (6) @(posedge sys_clk);
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Watchdog well beyond the few thousand cycles the tests need
	initial begin
		#(30000 * 100);
		bad_count++;
		print_verdict();
	end
	initial begin
		logic [31:0] v;
		logic en, pol, cen, cpol, r;
		int b, o;
		static int d3[8] = '{1, 1, 1, 1, 2, 3, 3, 1};
		static int d4[8] = '{2, 2, 2, 2, 1, 3, 3, 1};
		static int ps[8] = '{0, 1, 2, 3, 0, 0, 0, 0};
		static int pn[8] = '{0, 0, 0, 0, 1, 2, 2, 1};
		static int tg[8] = '{0, 0, 0, 0, 0, 0, 1, 0};
		repeat (8) @(posedge sys_clk);
		rst_b <= 1;
		mrd(8'h1C);
		mrd(8'h20);
		mrd(8'h40);
		mrd(8'h30);
		mwr(8'h50, rnd());
		mwr(8'h44, rnd());
		$display("test reset done");
		// Random words with random enables, so the direction lock is hit both ways
		repeat (30) begin
			v = rnd();
			o = v[4] ? 32'h20 : 32'h1C;
			mwr(o[7:0], rnd() & (v[4] ? `CCEN_MASK_ADV : `MODE34_MASK_ADV));
			mrd(8'h1C);
			mrd(8'h20);
		end
		mwr(8'h20, 32'h0);
		for (int m = 0; m < 8; m++) begin
			mwr(8'h1C, m << 4 | m << 12 | (m & 3) | (m & 3) << 8);
			mrd(8'h1C);
		end
		$display("test registers done");
		// Output levels over every enable and polarity mix, run off-state selected
		mwr(8'h40, 32'h0000000A);
		for (int c = 0; c < 4; c++) begin
			for (int k = 0; k < 16; k++) begin
				b = c < 2 ? 4 * c : 8 + 4 * c;
				o = c < 2 ? c : c + 2;
				mwr(8'h20, k << b);
				v = rnd();
				@(posedge sys_clk);
				oc_ref_in <= v[3:0];
				repeat (3) @(posedge sys_clk);
				@(negedge sys_clk);
				en = ccen_m[b];
				pol = ccen_m[b + 1];
				cen = ccen_m[b + 2];
				cpol = ccen_m[b + 3];
				r = v[c];
				chk_pin("main", en ? r ^ pol : pol, ch_output[o]);
				chk_pin("main_oe", en | cen, ch_output_oe[o]);
				if (c < 2) begin
					chk_pin("comp", cen ? (en ? !r : r) ^ cpol : cpol, ch_comp_output[c]);
					chk_pin("comp_oe", cen | en, ch_comp_output_oe[c]);
				end
			end
		end
		// Main output off: idle levels shown, driven since idle off-state is selected
		mwr(8'h20, 32'h5);
		mwr(8'h40, 32'h00000014);
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		chk_pin("idle", 1'b1, ch_output[0]);
		chk_pin("idle_oe", 1'b1, ch_output_oe[0]);
		chk_pin("comp_idle", 1'b0, ch_comp_output[0]);
		$display("test outputs done");
		// Capture mapping, prescale ratios and trigger gating; off between rows clears counts
		for (int i = 0; i < 8; i++) begin
			mwr(8'h20, 32'h0);
			mwr(8'h1C, d3[i] | ps[i] << 2 | d4[i] << 8 | ps[i] << 10);
			mwr(8'h40, tg[i]);
			mwr(8'h20, 32'h1100);
			@(posedge sys_clk);
			n3 = 0;
			n4 = 0;
			pulse(pn[i]);
			chk_reg("cap3", src(d3[i], 0, tg[i]) == pn[i] ? 8 >> ps[i] : 0, n3);
			chk_reg("cap4", src(d4[i], 1, tg[i]) == pn[i] ? 8 >> ps[i] : 0, n4);
		end
		// Enables off: pin edges must not capture
		mwr(8'h20, 32'h0);
		n3 = 0;
		n4 = 0;
		pulse(0);
		chk_reg("cap_off", 0, n3 + n4);
		$display("test capture done");
		// Compare modes on ch3/ch4 from a forced start level, one match pulse each
		mwr(8'h1C, 32'h0);
		mwr(8'h40, 32'h0000000A);
		for (int m = 0; m < 8; m++) begin
			v = rnd();
			mwr(8'h20, 32'h1100 | v & 32'hEE00);
			mwr(8'h1C, v[2] ? 32'h5050 : 32'h4040);
			mwr(8'h1C, m << 4 | m << 12);
			cmp_match <= 2'h3;
			cmp_below <= v[1:0];
			@(posedge sys_clk);
			cmp_match <= 2'h0;
			repeat (2) @(posedge sys_clk);
			@(negedge sys_clk);
			for (int c = 0; c < 2; c++) begin
				r = m inside {1, 5} ? 1'b1 : m == 3 ? ~v[2] : m == 6 ? v[c]
					: m == 7 ? ~v[c] : m == 0 && v[2];
				pol = ccen_m[9 + 4 * c];
				cen = ccen_m[10 + 4 * c];
				cpol = ccen_m[11 + 4 * c];
				chk_pin("ref_main", r ^ pol, ch_output[2 + c]);
				chk_pin("ref_oe", 1'b1, ch_output_oe[2 + c]);
				chk_pin("ref_comp", cen ? ~r ^ cpol : cpol, ch_comp_output[2 + c]);
			end
		end
		// Clear input beats force high on ch3 only, where its clear enable is set
		mwr(8'h1C, 32'h50D0);
		ref_clear_in <= 1'b1;
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk);
		chk_pin("clear3", ccen_m[9], ch_output[2]);
		chk_pin("clear4", ~ccen_m[13], ch_output[3]);
		@(posedge sys_clk);
		ref_clear_in <= 1'b0;
		$display("test compare done");
		print_verdict();
	end
endmodule
`default_nettype wire

// ### hdl/capture_prescale.v
// Capture event prescaler: one capture pulse every 1, 2, 4 or 8 input events
`timescale 1ns/1ps
`default_nettype none
module capture_prescale (
	// Clock and reset
	input wire sys_clk,
	input wire rst_b,
	input wire clk_en,
	// Control and events
	input wire capture_on,
	input wire [1:0] ratio,
	input wire event_in,
	// Result
	output reg capture_pulse_q
);
	reg [2:0] count_q;
	wire [2:0] last_count;

	// Events per capture minus one: 00 -> 0, 01 -> 1, 10 -> 3, 11 -> 7
	assign last_count = (3'h1 << ratio) - 3'h1;

	// Counter held at zero while the channel is off, so a restart begins a fresh group
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			count_q <= 3'h0;
			capture_pulse_q <= 1'b0;
		end else if (clk_en) begin
			capture_pulse_q <= 1'b0;
			if (!capture_on) begin
				count_q <= 3'h0;
			end else if (event_in) begin
				if (count_q >= last_count) begin
					count_q <= 3'h0;
					capture_pulse_q <= 1'b1;
				end else begin
					count_q <= count_q + 3'h1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### hdl/ccmode_consts.vh
// Register offsets, field positions, reset values and codes of the channel mode/enable block
`ifndef CCMODE_CONSTS_VH
`define CCMODE_CONSTS_VH
`define REG_MODE34_OFS 8'h1C
`define REG_CCEN_OFS 8'h20
`define REG_CFG_OFS 8'h40
`define REG_STAT_OFS 8'h44
`define MODE34_RST 32'h00000000
`define CCEN_RST 32'h00000000
`define CFG_RST 32'h00000000
`define MODE34_MASK_ADV 32'h0421FFFF
`define MODE34_MASK_STD 32'h0000FFFF
`define CCEN_MASK_ADV 32'h0033FFFF
`define CCEN_MASK_STD 32'h00333FFF
`define CFG_MASK 32'h00000FFF
`define CH3_DIR_LSB 0
`define CH4_DIR_LSB 8
`define CH3_FAST_POS 2
`define CH4_FAST_POS 10
`define CH3_PRE_POS 3
`define CH4_PRE_POS 11
`define CH3_MODE_LSB 4
`define CH4_MODE_LSB 12
`define CH3_CLR_POS 7
`define CH4_CLR_POS 15
`define CH3_PSC_LSB 2
`define CH4_PSC_LSB 10
`define CH3_FILT_LSB 4
`define CH4_FILT_LSB 12
`define CH7_PRE_POS 16
`define CH8_PRE_POS 21
`define CH9_PRE_POS 26
`define CCEN_STRIDE 4
`define CCEN_EN_OFS 0
`define CCEN_POL_OFS 1
`define CCEN_CEN_OFS 2
`define CCEN_CPOL_OFS 3
`define CH5_EN_POS 16
`define CH5_POL_POS 17
`define CH6_EN_POS 20
`define CH6_POL_POS 21
`define CFG_TRIG_INT_POS 0
`define CFG_MOE_POS 1
`define CFG_IDLE_OFF_STATE_SELECT_POS 2
`define CFG_RUN_OFF_STATE_SELECT_POS 3
`define CFG_IDLE_LSB 4
`define CFG_CIDLE_LSB 8
`define DIR_OUTPUT 2'h0
`define DIR_OWN 2'h1
`define DIR_OTHER 2'h2
`define DIR_TRIG 2'h3
`define OCM_FROZEN 3'h0
`define OCM_SET 3'h1
`define OCM_CLEAR 3'h2
`define OCM_TOGGLE 3'h3
`define OCM_FORCE_LO 3'h4
`define OCM_FORCE_HI 3'h5
`define OCM_PWM1 3'h6
`define OCM_PWM2 3'h7
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### hdl/ccmode_regs.v
// Channel 3/4 mode register, channel enable/polarity register and their channel logic
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ccmode_consts.vh"
module ccmode_regs #(
	parameter ADVANCED = 1
) (
	// Clock, reset, clock enable
	input wire sys_clk,
	input wire rst_b,
	input wire clk_en,
	// AXI4-Lite write address and data
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Timer input pins and trigger, asynchronous
	input wire timer_input_3,
	input wire timer_input_4,
	input wire internal_trigger_source,
	// Compare events from the counter logic, same clock
	input wire [1:0] cmp_match,
	input wire [1:0] cmp_below,
	input wire ref_clear_in,
	input wire [3:0] oc_ref_in,
	// Channel outputs
	output reg [5:0] ch_output,
	output reg [5:0] ch_output_oe,
	output reg [3:0] ch_comp_output,
	output reg [3:0] ch_comp_output_oe,
	// Capture results for channels 3 and 4
	output wire [1:0] capture_pulse,
	// Settings for the compare value and filter logic
	output wire [4:0] preload_en,
	output wire [1:0] fast_en,
	output wire [3:0] ch3_input_filter,
	output wire [3:0] ch4_input_filter
);
	localparam [31:0] MODE_MASK = ADVANCED ? `MODE34_MASK_ADV : `MODE34_MASK_STD;
	localparam [31:0] CCEN_MASK = ADVANCED ? `CCEN_MASK_ADV : `CCEN_MASK_STD;

	reg [31:0] mode_q;
	reg [31:0] ccen_q;
	reg [31:0] cfg_q;
	reg [31:0] mode_d;
	reg [31:0] ccen_d;
	reg [7:0] awaddr_q;
	reg aw_got_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg w_got_q;
	reg [2:0] pin_meta_q;
	reg [2:0] pin_sync_q;
	reg [1:0] cap_level_q;
	reg [1:0] cmp_ref_q;
	wire [31:0] byte_mask;
	wire trig_internal;
	wire [5:0] ref_all;
	wire [5:0] ch_is_out;
	reg [31:0] rd_data;
	reg rd_ok;

	// Writes only touch lanes whose strobe is set
	assign byte_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	assign trig_internal = cfg_q[`CFG_TRIG_INT_POS];

	// Register fields handed to neighbouring logic straight from the flops
	assign preload_en = {mode_q[`CH9_PRE_POS], mode_q[`CH8_PRE_POS], mode_q[`CH7_PRE_POS],
		mode_q[`CH4_PRE_POS], mode_q[`CH3_PRE_POS]};
	assign fast_en = {mode_q[`CH4_FAST_POS], mode_q[`CH3_FAST_POS]};
	assign ch3_input_filter = mode_q[`CH3_FILT_LSB+3:`CH3_FILT_LSB];
	assign ch4_input_filter = mode_q[`CH4_FILT_LSB+3:`CH4_FILT_LSB];

	// Next register values; reserved and absent bits never store a one
	always @* begin
		mode_d = (mode_q & ~(byte_mask & MODE_MASK)) | (wdata_q & byte_mask & MODE_MASK);
		if (ccen_q[2 * `CCEN_STRIDE + `CCEN_EN_OFS]) begin
			mode_d[`CH3_DIR_LSB+1:`CH3_DIR_LSB] = mode_q[`CH3_DIR_LSB+1:`CH3_DIR_LSB];
		end
		if (ccen_q[3 * `CCEN_STRIDE + `CCEN_EN_OFS]) begin
			mode_d[`CH4_DIR_LSB+1:`CH4_DIR_LSB] = mode_q[`CH4_DIR_LSB+1:`CH4_DIR_LSB];
		end
		ccen_d = (ccen_q & ~(byte_mask & CCEN_MASK)) | (wdata_q & byte_mask & CCEN_MASK);
	end

	// Write channel: address and data taken in either order, then one cycle to respond
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			mode_q <= `MODE34_RST;
			ccen_q <= `CCEN_RST;
			cfg_q <= `CFG_RST;
		end else if (clk_en) begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_q <= s_axi_awaddr;
				aw_got_q <= 1'b1;
				s_axi_awready <= 1'b0;
			end else if (!aw_got_q && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				w_got_q <= 1'b1;
				s_axi_wready <= 1'b0;
			end else if (!w_got_q && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
			if (aw_got_q && w_got_q && !s_axi_bvalid) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `RESP_OKAY;
				if (awaddr_q == `REG_MODE34_OFS) begin
					mode_q <= mode_d;
				end else if (awaddr_q == `REG_CCEN_OFS) begin
					ccen_q <= ccen_d;
				end else if (awaddr_q == `REG_CFG_OFS) begin
					cfg_q <= (cfg_q & ~(byte_mask & `CFG_MASK)) | (wdata_q & byte_mask & `CFG_MASK);
				end else if (awaddr_q != `REG_STAT_OFS) begin
					s_axi_bresp <= `RESP_SLVERR; // Unmapped, nothing stored
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Read decode; the status word shows live channel state
	always @* begin
		rd_ok = 1'b1;
		rd_data = 32'h00000000;
		if (s_axi_araddr == `REG_MODE34_OFS) begin
			rd_data = mode_q;
		end else if (s_axi_araddr == `REG_CCEN_OFS) begin
			rd_data = ccen_q;
		end else if (s_axi_araddr == `REG_CFG_OFS) begin
			rd_data = cfg_q;
		end else if (s_axi_araddr == `REG_STAT_OFS) begin
			rd_data = {16'h0000, ch_comp_output_oe, ch_output_oe[3:0], 2'h0, cmp_ref_q, cap_level_q, 2'h0};
		end else begin
			rd_ok = 1'b0;
		end
	end

	// Read channel: data registered at the same edge that takes the address
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_data;
				s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end else if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Two-stage synchroniser for pins that live outside this clock
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_meta_q <= 3'h0;
			pin_sync_q <= 3'h0;
		end else if (clk_en) begin
			pin_meta_q <= {internal_trigger_source, timer_input_4, timer_input_3};
			pin_sync_q <= pin_meta_q;
		end
	end

	// Channels 3 and 4: input mapping, capture prescaler and compare reference
	genvar k;
	generate
		for (k = 0; k < 2; k = k + 1) begin : g_cap
			localparam DIR_LSB = (k == 0) ? `CH3_DIR_LSB : `CH4_DIR_LSB;
			localparam PSC_LSB = (k == 0) ? `CH3_PSC_LSB : `CH4_PSC_LSB;
			localparam MODE_LSB = (k == 0) ? `CH3_MODE_LSB : `CH4_MODE_LSB;
			localparam CLR_POS = (k == 0) ? `CH3_CLR_POS : `CH4_CLR_POS;
			localparam EN_POS = (k + 2) * `CCEN_STRIDE + `CCEN_EN_OFS;
			localparam POL_POS = (k + 2) * `CCEN_STRIDE + `CCEN_POL_OFS;
			wire [1:0] dir;
			wire [2:0] ocm;
			wire own_in;
			wire other_in;
			reg mapped;
			wire cap_on;
			assign dir = mode_q[DIR_LSB+1:DIR_LSB];
			assign ocm = mode_q[MODE_LSB+2:MODE_LSB];
			assign own_in = pin_sync_q[k]; // Ch3 owns input 3, ch4 owns input 4
			assign other_in = pin_sync_q[1-k];
			// Internal trigger mapping reads low unless the trigger selection is internal
			always @* begin
				case (dir)
					`DIR_OWN: mapped = own_in;
					`DIR_OTHER: mapped = other_in;
					`DIR_TRIG: mapped = trig_internal & pin_sync_q[2];
					default: mapped = 1'b0;
				endcase
			end
			assign cap_on = ccen_q[EN_POS] && (dir != `DIR_OUTPUT);
			// Polarity picks the input or its inverse, and the capture edge follows it
			always @(posedge sys_clk or negedge rst_b) begin
				if (!rst_b) begin
					cap_level_q[k] <= 1'b0;
				end else if (clk_en) begin
					cap_level_q[k] <= mapped ^ ccen_q[POL_POS];
				end
			end
			capture_prescale u_psc (
				.sys_clk(sys_clk),
				.rst_b(rst_b),
				.clk_en(clk_en),
				.capture_on(cap_on),
				.ratio(mode_q[PSC_LSB+1:PSC_LSB]),
				.event_in((mapped ^ ccen_q[POL_POS]) & ~cap_level_q[k]),
				.capture_pulse_q(capture_pulse[k])
			);
			// Reference level per compare mode; clear input overrides every mode when the channel's clear enable bit is set
			always @(posedge sys_clk or negedge rst_b) begin
				if (!rst_b) begin
					cmp_ref_q[k] <= 1'b0;
				end else if (clk_en) begin
					if (mode_q[CLR_POS] && ref_clear_in) begin
						cmp_ref_q[k] <= 1'b0;
					end else begin
						case (ocm)
							`OCM_SET: cmp_ref_q[k] <= cmp_match[k] | cmp_ref_q[k];
							`OCM_CLEAR: cmp_ref_q[k] <= ~cmp_match[k] & cmp_ref_q[k];
							`OCM_TOGGLE: cmp_ref_q[k] <= cmp_match[k] ^ cmp_ref_q[k];
							`OCM_FORCE_LO: cmp_ref_q[k] <= 1'b0;
							`OCM_FORCE_HI: cmp_ref_q[k] <= 1'b1;
							`OCM_PWM1: cmp_ref_q[k] <= cmp_below[k];
							`OCM_PWM2: cmp_ref_q[k] <= ~cmp_below[k];
							default: cmp_ref_q[k] <= cmp_ref_q[k]; // Frozen
						endcase
					end
				end
			end
		end
	endgenerate

	assign ref_all = {oc_ref_in[3:2], cmp_ref_q, oc_ref_in[1:0]};
	// Only ch3/ch4 directions live here; the others are taken as outputs
	assign ch_is_out = {2'h3, mode_q[`CH4_DIR_LSB+1:`CH4_DIR_LSB] == `DIR_OUTPUT,
		mode_q[`CH3_DIR_LSB+1:`CH3_DIR_LSB] == `DIR_OUTPUT, 2'h3};

	// Output stage per channel; dead time is left to the break logic downstream
	genvar i;
	generate
		for (i = 0; i < 6; i = i + 1) begin : g_out
			localparam EN_POS = (i < 4) ? i * `CCEN_STRIDE + `CCEN_EN_OFS
				: ((i == 4) ? `CH5_EN_POS : `CH6_EN_POS);
			localparam POL_POS = (i < 4) ? i * `CCEN_STRIDE + `CCEN_POL_OFS
				: ((i == 4) ? `CH5_POL_POS : `CH6_POL_POS);
			wire en;
			wire pol;
			wire cen;
			wire cpol;
			wire moe;
			wire idle_off_state_select;
			wire run_off_state_select;
			assign en = ccen_q[EN_POS] & ch_is_out[i];
			assign pol = ccen_q[POL_POS];
			assign cen = (i < 4) ? ccen_q[i * `CCEN_STRIDE + `CCEN_CEN_OFS] & ch_is_out[i] : 1'b0;
			assign cpol = (i < 4) ? ccen_q[i * `CCEN_STRIDE + `CCEN_CPOL_OFS] : 1'b0;
			assign moe = cfg_q[`CFG_MOE_POS];
			assign idle_off_state_select = cfg_q[`CFG_IDLE_OFF_STATE_SELECT_POS];
			assign run_off_state_select = cfg_q[`CFG_RUN_OFF_STATE_SELECT_POS];
			always @(posedge sys_clk or negedge rst_b) begin
				if (!rst_b) begin
					ch_output[i] <= 1'b0;
					ch_output_oe[i] <= 1'b0;
				end else if (clk_en) begin
					if (!moe) begin
						ch_output[i] <= (i < 4) ? cfg_q[`CFG_IDLE_LSB + (i % 4)] : 1'b0;
						ch_output_oe[i] <= idle_off_state_select & ch_is_out[i];
					end else if (en) begin
						ch_output[i] <= ref_all[i] ^ pol;
						ch_output_oe[i] <= 1'b1;
					end else begin
						ch_output[i] <= run_off_state_select & pol;
						ch_output_oe[i] <= run_off_state_select & cen;
					end
				end
			end
			if (i < 4) begin : g_comp
				// Complementary side inverts the reference only when the main side also runs
				always @(posedge sys_clk or negedge rst_b) begin
					if (!rst_b) begin
						ch_comp_output[i] <= 1'b0;
						ch_comp_output_oe[i] <= 1'b0;
					end else if (clk_en) begin
						if (!moe) begin
							ch_comp_output[i] <= cfg_q[`CFG_CIDLE_LSB + i];
							ch_comp_output_oe[i] <= idle_off_state_select & ch_is_out[i];
						end else if (cen) begin
							ch_comp_output[i] <= (en ? ~ref_all[i] : ref_all[i]) ^ cpol;
							ch_comp_output_oe[i] <= 1'b1;
						end else begin
							ch_comp_output[i] <= run_off_state_select & cpol;
							ch_comp_output_oe[i] <= run_off_state_select & en;
						end
					end
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire
